//--- irqf_pkg.sv
// Package with register map, bit layout and reset values of the interrupt flag block
package irqf_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned GROUPS = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [31:0] CLEAR_ADDR = 32'h00003004;
  localparam logic [31:0] ENABLE0_ADDR = 32'h00003008;
  localparam logic [31:0] ENABLE1_ADDR = 32'h0000300c;
  localparam logic [31:0] PENDING0_ADDR = 32'h00003010;
  localparam logic [31:0] PENDING1_ADDR = 32'h00003014;
  localparam logic [31:0] LINE_STATUS_ADDR = 32'h00003018;

  ////////////////////////////////////////////////////////////////////////////
  // Flag bit positions
  localparam int unsigned SEQ_COLLISION_BIT = 31;
  localparam int unsigned FIFO_UNDERFLOW_BIT = 27;
  localparam int unsigned FIFO_OVERFLOW_BIT = 26;
  localparam int unsigned FIFO_THRESHOLD_BIT = 25;
  localparam int unsigned FIFO_EMPTY_BIT = 24;
  localparam int unsigned FIFO_FULL_BIT = 23;
  localparam int unsigned SEQ_TIMEOUT_ERROR_BIT = 17;
  localparam int unsigned SEQ_TIMEOUT_DONE_BIT = 16;
  localparam int unsigned END_OF_SEQUENCE_BIT = 15;
  localparam int unsigned BOOT_LOAD_DONE_BIT = 13;

  // Line status register bit positions
  localparam int unsigned LINE_IRQ0_BIT = 0;
  localparam int unsigned LINE_IRQ1_BIT = 1;
  localparam int unsigned LINE_SEQ_BUSY_BIT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Implemented flag bits; all others are reserved and read as zero
  localparam logic [31:0] FLAG_IMPL_MASK = 32'h8f83a000;

  // Values after reset
  localparam logic [31:0] PENDING_RESET = 32'h00000000;
  localparam logic [31:0] ENABLE_RESET = 32'h00002000;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;

endpackage

//--- irqf_group.sv
// One interrupt output group: enable register, sticky pending flags, output line
`timescale 1ns/1ps
`default_nettype none

module irqf_group
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] set_i,
  input wire logic [31:0] clear_i,
  input wire logic enable_we_i,
  input wire logic [31:0] enable_wdata_i,
  input wire logic [31:0] enable_bmask_i,
  output logic [31:0] pending_o,
  output logic [31:0] enable_o,
  output logic irq_o
);

  logic [31:0] pending_reg;
  logic [31:0] pending_next;
  logic [31:0] enable_reg;
  logic [31:0] enable_next;
  logic irq_reg;
  logic irq_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    // Set wins over a clear in the same cycle so no event is lost
    pending_next = ((pending_reg & ~clear_i) | set_i) & irqf_pkg::FLAG_IMPL_MASK;
    enable_next = enable_reg;
    if (enable_we_i)
    begin
      enable_next = (enable_reg & ~enable_bmask_i) | (enable_wdata_i & enable_bmask_i);
    end
    enable_next = enable_next & irqf_pkg::FLAG_IMPL_MASK;
    // Line follows the same edge as the flags so a read never disagrees with it
    irq_next = |(pending_next & enable_next);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pending_reg <= irqf_pkg::PENDING_RESET;
      enable_reg <= irqf_pkg::ENABLE_RESET;
      irq_reg <= 1'b0;
    end
    else
    begin
      pending_reg <= pending_next;
      enable_reg <= enable_next;
      irq_reg <= irq_next;
    end
  end

  assign pending_o = pending_reg;
  assign enable_o = enable_reg;
  assign irq_o = irq_reg;

endmodule

`default_nettype wire

//--- irqf_top.sv
// Interrupt flag block: APB slave, two pending flag groups, sequence collision
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module irqf_top
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic seq_a_busy_i,
  input wire logic seq_b_req_i,
  input wire logic fifo_underflow_i,
  input wire logic fifo_overflow_i,
  input wire logic fifo_threshold_i,
  input wire logic fifo_empty_i,
  input wire logic fifo_full_i,
  input wire logic seq_timeout_error_i,
  input wire logic seq_timeout_done_i,
  input wire logic end_of_sequence_i,
  input wire logic boot_load_done_i,
  output logic seq_b_grant_o,
  output logic [1:0] irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Types and helpers

  typedef enum logic
  {
    IRQF_IDLE,
    IRQF_RESP
  } irqf_apb_state_e;

  // Word-aligned address match; low two bits are ignored as APB words are aligned
  function automatic logic irqf_hit(input logic [31:0] addr, input logic [31:0] reg_addr);
    irqf_hit = (addr[31:2] == reg_addr[31:2]);
  endfunction

  // Byte strobes widened to a bit mask
  function automatic logic [31:0] irqf_bmask(input logic [3:0] strb);
    irqf_bmask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  irqf_apb_state_e state_reg;
  irqf_apb_state_e state_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic grant_reg;
  logic grant_next;
  logic [1:0] irq_line;
  logic [31:0] event_set;
  logic [31:0] clear_vec;
  logic [31:0] wr_bmask;
  logic access_req;
  logic write_take;
  logic collision;
  logic addr_mapped;
  logic [31:0] read_word;
  logic [31:0] line_status;
  logic [31:0] pending_word [0:1];
  logic [31:0] enable_word [0:1];
  logic [1:0] enable_we;

  ////////////////////////////////////////////////////////////////////////////
  // Event collection

  // A start request that meets a running sequence is dropped, never queued
  always_comb
  begin
    collision = seq_b_req_i & seq_a_busy_i;
    grant_next = seq_b_req_i & ~seq_a_busy_i;
  end

  always_comb
  begin
    event_set = 32'h00000000;
    event_set[irqf_pkg::SEQ_COLLISION_BIT] = collision;
    event_set[irqf_pkg::FIFO_UNDERFLOW_BIT] = fifo_underflow_i;
    event_set[irqf_pkg::FIFO_OVERFLOW_BIT] = fifo_overflow_i;
    event_set[irqf_pkg::FIFO_THRESHOLD_BIT] = fifo_threshold_i;
    event_set[irqf_pkg::FIFO_EMPTY_BIT] = fifo_empty_i;
    event_set[irqf_pkg::FIFO_FULL_BIT] = fifo_full_i;
    event_set[irqf_pkg::SEQ_TIMEOUT_ERROR_BIT] = seq_timeout_error_i;
    event_set[irqf_pkg::SEQ_TIMEOUT_DONE_BIT] = seq_timeout_done_i;
    event_set[irqf_pkg::END_OF_SEQUENCE_BIT] = end_of_sequence_i;
    event_set[irqf_pkg::BOOT_LOAD_DONE_BIT] = boot_load_done_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      grant_reg <= 1'b0;
    end
    else
    begin
      grant_reg <= grant_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB access decode

  // One wait state: data is looked up in the first access cycle and registered
  always_comb
  begin
    access_req = psel_i & penable_i;
    write_take = access_req & pwrite_i & (state_reg == IRQF_RESP) & ~pslverr_reg;
    wr_bmask = irqf_bmask(pstrb_i);
  end

  always_comb
  begin
    addr_mapped = irqf_hit(paddr_i, irqf_pkg::CLEAR_ADDR)
                | irqf_hit(paddr_i, irqf_pkg::ENABLE0_ADDR)
                | irqf_hit(paddr_i, irqf_pkg::ENABLE1_ADDR)
                | irqf_hit(paddr_i, irqf_pkg::PENDING0_ADDR)
                | irqf_hit(paddr_i, irqf_pkg::PENDING1_ADDR)
                | irqf_hit(paddr_i, irqf_pkg::LINE_STATUS_ADDR);
  end

  // Clear acts on both groups; the clear register itself reads as zero
  always_comb
  begin
    clear_vec = 32'h00000000;
    if (write_take && irqf_hit(paddr_i, irqf_pkg::CLEAR_ADDR))
    begin
      clear_vec = pwdata_i & wr_bmask & irqf_pkg::FLAG_IMPL_MASK;
    end
  end

  always_comb
  begin
    enable_we[0] = write_take & irqf_hit(paddr_i, irqf_pkg::ENABLE0_ADDR);
    enable_we[1] = write_take & irqf_hit(paddr_i, irqf_pkg::ENABLE1_ADDR);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag groups

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gen_group
      irqf_group u_group
      (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(event_set),
        .clear_i(clear_vec),
        .enable_we_i(enable_we[g]),
        .enable_wdata_i(pwdata_i),
        .enable_bmask_i(wr_bmask),
        .pending_o(pending_word[g]),
        .enable_o(enable_word[g]),
        .irq_o(irq_line[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read back

  always_comb
  begin
    line_status = 32'h00000000;
    line_status[irqf_pkg::LINE_IRQ0_BIT] = irq_line[0];
    line_status[irqf_pkg::LINE_IRQ1_BIT] = irq_line[1];
    line_status[irqf_pkg::LINE_SEQ_BUSY_BIT] = seq_a_busy_i;
  end

  // Pending registers are read only; a write to them is accepted and dropped
  always_comb
  begin
    read_word = 32'h00000000;
    if (irqf_hit(paddr_i, irqf_pkg::PENDING0_ADDR))
    begin
      read_word = pending_word[0];
    end
    else if (irqf_hit(paddr_i, irqf_pkg::PENDING1_ADDR))
    begin
      read_word = pending_word[1];
    end
    else if (irqf_hit(paddr_i, irqf_pkg::ENABLE0_ADDR))
    begin
      read_word = enable_word[0];
    end
    else if (irqf_hit(paddr_i, irqf_pkg::ENABLE1_ADDR))
    begin
      read_word = enable_word[1];
    end
    else if (irqf_hit(paddr_i, irqf_pkg::LINE_STATUS_ADDR))
    begin
      read_word = line_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB response state machine

  always_comb
  begin
    state_next = state_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    case (state_reg)
      IRQF_IDLE:
      begin
        if (access_req)
        begin
          state_next = IRQF_RESP;
          pready_next = 1'b1;
          pslverr_next = ~addr_mapped;
          prdata_next = (pwrite_i || !addr_mapped) ? 32'h00000000 : read_word;
        end
      end
      IRQF_RESP:
      begin
        // Transfer completes at this edge; drop ready so the next one waits again
        state_next = IRQF_IDLE;
        prdata_next = irqf_pkg::RDATA_RESET;
      end
      default:
      begin
        state_next = IRQF_IDLE;
        prdata_next = irqf_pkg::RDATA_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= IRQF_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= irqf_pkg::RDATA_RESET;
    end
    else
    begin
      state_reg <= state_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign seq_b_grant_o = grant_reg;
  assign irq_o = irq_line;

endmodule

`default_nettype wire

//--- irqf_top_pad.sv
// Spare source of the interrupt flag block; it holds no code

//--- irqf_chk.sv
// Checker of bus handshake, sequence collision and interrupt line timing
`timescale 1ns/1ps
`default_nettype none
module irqf_chk
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic seq_a_busy_i,
  input wire logic seq_b_req_i,
  input wire logic fifo_underflow_i,
  input wire logic fifo_overflow_i,
  input wire logic fifo_threshold_i,
  input wire logic fifo_empty_i,
  input wire logic fifo_full_i,
  input wire logic seq_timeout_error_i,
  input wire logic seq_timeout_done_i,
  input wire logic end_of_sequence_i,
  input wire logic boot_load_done_i,
  input wire logic seq_b_grant_o,
  input wire logic [1:0] irq_o
);
  logic wr_done;
  logic ev_any;
  assign wr_done = psel_i && penable_i && pwrite_i && pready_o;
  assign ev_any = fifo_underflow_i | fifo_overflow_i | fifo_threshold_i | fifo_empty_i
    | fifo_full_i | seq_timeout_error_i | seq_timeout_done_i | end_of_sequence_i
    | boot_load_done_i | (seq_b_req_i & seq_a_busy_i);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////////////
  AST_COLLIDE_DROP: assert property (seq_b_req_i && seq_a_busy_i |=> !seq_b_grant_o)
    else $error("Colliding request was passed on");
  AST_GRANT_PASS: assert property (seq_b_req_i && !seq_a_busy_i |=> seq_b_grant_o)
    else $error("Free request was not passed on");
  AST_READY_WAIT: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("Ready missing after access cycle");
  AST_READY_PULSE: assert property (pready_o |=> !pready_o)
    else $error("Ready held longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
    else $error("Error without ready");
  AST_RDATA_QUIET: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("Read data not zero outside answer");
  AST_IRQ_STICKY: assert property ((|(~irq_o & $past(irq_o))) |-> $past(wr_done))
    else $error("Interrupt line fell without a write");
  AST_IRQ_CAUSE: assert property ((|(irq_o & ~$past(irq_o))) |-> $past(ev_any || wr_done))
    else $error("Interrupt line rose without cause");
endmodule
bind irqf_top irqf_chk i_irqf_chk (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .seq_a_busy_i(seq_a_busy_i), .seq_b_req_i(seq_b_req_i),
  .fifo_underflow_i(fifo_underflow_i), .fifo_overflow_i(fifo_overflow_i),
  .fifo_threshold_i(fifo_threshold_i), .fifo_empty_i(fifo_empty_i),
  .fifo_full_i(fifo_full_i), .seq_timeout_error_i(seq_timeout_error_i),
  .seq_timeout_done_i(seq_timeout_done_i), .end_of_sequence_i(end_of_sequence_i),
  .boot_load_done_i(boot_load_done_i), .seq_b_grant_o(seq_b_grant_o), .irq_o(irq_o));
`default_nettype wire

//--- tb.sv
// Testbench of the interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic busy = 1'b0;
  logic req = 1'b0;
  logic [8:0] ev = 9'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic grant;
  logic [1:0] irq;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  typedef struct packed
  {
    logic [8:0] ev;
    logic busy;
    logic req;
    logic [31:0] flags;
    logic [1:0] lines;
  } irqf_row_s;
  // One event pulse per row, beside the flag word and interrupt lines it must give
  irqf_row_s rows [10] = '{
    {9'h000, 1'b1, 1'b1, 32'h80000000, 2'h0},
    {9'h001, 1'b0, 1'b0, 32'h08000000, 2'h0},
    {9'h002, 1'b0, 1'b0, 32'h04000000, 2'h0},
    {9'h004, 1'b0, 1'b0, 32'h02000000, 2'h0},
    {9'h008, 1'b0, 1'b0, 32'h01000000, 2'h0},
    {9'h010, 1'b0, 1'b0, 32'h00800000, 2'h0},
    {9'h020, 1'b0, 1'b0, 32'h00020000, 2'h0},
    {9'h040, 1'b0, 1'b0, 32'h00010000, 2'h0},
    {9'h080, 1'b0, 1'b0, 32'h00008000, 2'h0},
    {9'h100, 1'b0, 1'b0, 32'h00002000, 2'h3}
  };
  irqf_top i_irqf_top (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .seq_a_busy_i(busy),
    .seq_b_req_i(req), .fifo_underflow_i(ev[0]), .fifo_overflow_i(ev[1]),
    .fifo_threshold_i(ev[2]), .fifo_empty_i(ev[3]), .fifo_full_i(ev[4]),
    .seq_timeout_error_i(ev[5]), .seq_timeout_done_i(ev[6]), .end_of_sequence_i(ev[7]),
    .boot_load_done_i(ev[8]), .seq_b_grant_o(grant), .irq_o(irq));
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Holds the request until ready is sampled high; the global cycle limit ends a hang
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic pulse(input logic [8:0] e, input logic b, input logic r);
    @(posedge clk_i);
    ev <= e;
    busy <= b;
    req <= r;
    @(posedge clk_i);
    ev <= 9'h0;
    busy <= 1'b0;
    req <= 1'b0;
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      final_report;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(irqf_pkg::PENDING0_ADDR, 32'h0);
    rchk(irqf_pkg::PENDING1_ADDR, 32'h0);
    rchk(irqf_pkg::ENABLE0_ADDR, 32'h00002000);
    for (int i = 0; i < 10; i++)
    begin
      pulse(rows[i].ev, rows[i].busy, rows[i].req);
      @(posedge clk_i);
      chk({30'h0, irq}, {30'h0, rows[i].lines});
      chk({31'h0, grant}, 32'h0);
      rchk(irqf_pkg::PENDING0_ADDR, rows[i].flags);
      rchk(irqf_pkg::PENDING1_ADDR, rows[i].flags);
      apb(1'b1, irqf_pkg::CLEAR_ADDR, 32'hffffffff);
      rchk(irqf_pkg::PENDING0_ADDR, 32'h0);
    end
    // Awkward cases: ignored writes, write of zero, set against clear, masking, strobes
    pulse(9'h100, 1'b0, 1'b0);
    apb(1'b1, irqf_pkg::PENDING0_ADDR, 32'h0);
    rchk(irqf_pkg::PENDING0_ADDR, 32'h00002000);
    apb(1'b1, irqf_pkg::CLEAR_ADDR, 32'hffffdfff);
    rchk(irqf_pkg::PENDING1_ADDR, 32'h00002000);
    // Event lands on the clear edge; the flag must survive it
    fork
      apb(1'b1, irqf_pkg::CLEAR_ADDR, 32'h00002000);
      begin
        do @(posedge clk_i); while (!(psel && penable));
        ev <= 9'h100;
        @(posedge clk_i);
        ev <= 9'h0;
      end
    join
    rchk(irqf_pkg::PENDING1_ADDR, 32'h00002000);
    apb(1'b1, irqf_pkg::ENABLE0_ADDR, 32'h0);
    @(posedge clk_i);
    chk({30'h0, irq}, 32'h2);
    apb(1'b1, irqf_pkg::ENABLE0_ADDR, 32'hffffffff);
    rchk(irqf_pkg::ENABLE0_ADDR, 32'h8f83a000);
    busy <= 1'b1;
    rchk(irqf_pkg::LINE_STATUS_ADDR, 32'h00000007);
    busy <= 1'b0;
    pstrb <= 4'hd;
    apb(1'b1, irqf_pkg::ENABLE1_ADDR, 32'h0);
    rchk(irqf_pkg::ENABLE1_ADDR, 32'h00002000);
    pstrb <= 4'h2;
    apb(1'b1, irqf_pkg::ENABLE1_ADDR, 32'h0);
    pstrb <= 4'hf;
    @(posedge clk_i);
    chk({30'h0, irq}, 32'h1);
    apb(1'b0, 32'h00003100, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    pulse(9'h0, 1'b0, 1'b1);
    @(posedge clk_i);
    chk({31'h0, grant}, 32'h1);
    rchk(irqf_pkg::PENDING0_ADDR, 32'h00002000);
    // Reset in mid-run; held long enough that no checker sees the line fall unguarded
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk({30'h0, irq}, 32'h0);
    rst_i <= 1'b0;
    rchk(irqf_pkg::PENDING0_ADDR, 32'h0);
    rchk(irqf_pkg::PENDING1_ADDR, 32'h0);
    rchk(irqf_pkg::ENABLE1_ADDR, 32'h00002000);
    final_report;
  end
endmodule
`default_nettype wire
